// ### rtl/rnv_pkg.sv
// rnv_pkg: register map, field layout, reset values and timing for the bank
package rnv_pkg;
  localparam logic [7:0] ADDR_TEMP = 8'h20;
  localparam logic [7:0] ADDR_NV_CONFIG = 8'h30;
  localparam logic [7:0] ADDR_CRYSTAL_OFFSET = 8'h31;
  localparam logic [7:0] ADDR_CRYSTAL_QUAD_COEF = 8'h32;
  localparam logic [7:0] ADDR_CRYSTAL_TURNOVER_TEMP = 8'h33;
  localparam logic [7:0] ADDR_USER_RAM_FIRST = 8'h38;
  localparam logic [7:0] ADDR_USER_RAM_LAST = 8'h3F;
  localparam int USER_RAM_DEPTH = 8;
  localparam int USER_RAM_AW = 3;

  localparam int TRICKLE_LSB = 4;
  localparam int TRICKLE_W = 4;
  localparam int CLOCK_OUTPUT_PIN_SEL_LSB = 2;
  localparam int CLOCK_OUTPUT_PIN_SEL_W = 2;
  localparam int THERM_EN_BIT = 1;
  localparam int SCAN_SEL_BIT = 0;
  localparam int OFFSET_SIGN_BIT = 7;
  localparam int OFFSET_MAG_W = 7;
  localparam int TURNOVER_W = 6;

  localparam logic [7:0] NV_CONFIG_RST = 8'h00;
  localparam logic [7:0] CRYSTAL_OFFSET_RST = 8'h00;
  localparam logic [7:0] CRYSTAL_QUAD_COEF_RST = 8'h00;
  localparam logic [5:0] CRYSTAL_TURNOVER_RST = 6'h00;
  localparam logic [7:0] TEMP_RST = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned SCAN_SHORT_S = 1;
  localparam int unsigned SCAN_LONG_S = 16;
  localparam int unsigned SCAN_SHORT_CYC = SCAN_SHORT_S * CLK_HZ;
  localparam int unsigned SCAN_LONG_CYC = SCAN_LONG_S * CLK_HZ;

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [6:0] BUS_ADDR_DEFAULT = 7'h56;

  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } rnv_wr_type;

  typedef struct packed {
    logic signed [7:0] offset;
    logic [7:0] quad_coef;
    logic [5:0] turnover;
  } rnv_comp_type;
endpackage : rnv_pkg

// ### rtl/rnv_scan_timer.sv
// rnv_scan_timer: periodic tick for the temperature scan
`timescale 1ns/1ps
module rnv_scan_timer #(
  parameter int unsigned SHORT_CYC = rnv_pkg::SCAN_SHORT_CYC,
  parameter int unsigned LONG_CYC = rnv_pkg::SCAN_LONG_CYC
) (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic run_in,
  input wire logic long_sel_in,
  output logic tick_out
);
  logic [31:0] cnt_q;
  logic [31:0] limit;

  assign limit = long_sel_in ? LONG_CYC - 32'h1 : SHORT_CYC - 32'h1;

  // restart on stop so the first scan comes one full period after enable
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_q <= 32'h0;
    end else if (!run_in || cnt_q >= limit) begin
      cnt_q <= 32'h0;
    end else begin
      cnt_q <= cnt_q + 32'h1;
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tick_out <= 1'b0;
    end else begin
      tick_out <= run_in && cnt_q >= limit;
    end
  end
endmodule : rnv_scan_timer

// ### rtl/rnv_config_ram.sv
// rnv_config_ram: configuration, crystal trim and user RAM behind the bus
`timescale 1ns/1ps
module rnv_config_ram #(
  parameter logic [6:0] BUS_ADDR = rnv_pkg::BUS_ADDR_DEFAULT,
  parameter int unsigned SCAN_SHORT_CYC = rnv_pkg::SCAN_SHORT_CYC,
  parameter int unsigned SCAN_LONG_CYC = rnv_pkg::SCAN_LONG_CYC
) (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  input wire logic backup_mode_in,
  input wire logic low_supply_level_one_in,
  input wire logic low_supply_level_two_in,
  input wire logic low_one_int_en_in,
  input wire logic low_two_int_en_in,
  input wire logic low_one_clr_in,
  input wire logic low_two_clr_in,
  input wire logic [7:0] temp_result_in,
  input wire logic temp_result_valid_in,
  output logic temp_meas_req_out,
  output logic [7:0] temp_value_out,
  output logic trickle_res_largest_en_out,
  output logic trickle_res_large_en_out,
  output logic trickle_res_medium_en_out,
  output logic trickle_res_small_en_out,
  output logic clock_output_en_out,
  output logic clock_output_pin_freq_sel_hi_out,
  output logic clock_output_pin_freq_sel_lo_out,
  output logic low_one_flag_out,
  output logic low_two_flag_out,
  output logic int_out,
  output rnv_pkg::rnv_comp_type comp_out
);
  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_ADDR = 7'b0000010,
    ST_ADDR_ACK = 7'b0000100,
    ST_WR_BYTE = 7'b0001000,
    ST_WR_ACK = 7'b0010000,
    ST_RD_BYTE = 7'b0100000,
    ST_RD_ACK = 7'b1000000
  } rnv_state_type;

  rnv_state_type state_q;
  logic scl_q;
  logic sda_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic read_dir_q;
  logic ptr_loaded_q;
  logic master_ack_q;
  logic drive_low_q;
  logic [7:0] ptr_q;
  rnv_pkg::rnv_wr_type wr_q;

  logic [7:0] nv_config_q;
  logic [7:0] crystal_offset_q;
  logic [7:0] crystal_quad_coef_q;
  logic [5:0] crystal_turnover_q;
  logic [7:0] temp_q;
  logic [7:0] user_ram_q [rnv_pkg::USER_RAM_DEPTH];
  logic low_one_q;
  logic low_two_q;

  logic start_cond;
  logic stop_cond;
  logic scl_rise;
  logic scl_fall;
  logic [7:0] rd_data;
  logic therm_en;
  logic therm_run;
  logic scan_tick;
  logic [7:0] shift_next;

  function automatic logic is_user_ram(input logic [7:0] a);
    return a >= rnv_pkg::ADDR_USER_RAM_FIRST &&
           a <= rnv_pkg::ADDR_USER_RAM_LAST;
  endfunction : is_user_ram

  function automatic logic [rnv_pkg::USER_RAM_AW-1:0] ram_idx(
    input logic [7:0] a);
    logic [7:0] d;
    d = a - rnv_pkg::ADDR_USER_RAM_FIRST;
    return d[rnv_pkg::USER_RAM_AW-1:0];
  endfunction : ram_idx

  assign start_cond = scl_in && scl_q && sda_q && !sda_in;
  assign stop_cond = scl_in && scl_q && !sda_q && sda_in;
  assign scl_rise = scl_in && !scl_q;
  assign scl_fall = !scl_in && scl_q;
  assign shift_next = {shift_q[6:0], sda_in};

  // read mux; unmapped addresses answer zero
  always_comb begin
    rd_data = rnv_pkg::READ_UNMAPPED;
    if (is_user_ram(ptr_q)) begin
      rd_data = user_ram_q[ram_idx(ptr_q)];
    end else begin
      case (ptr_q)
        rnv_pkg::ADDR_TEMP: rd_data = temp_q;
        rnv_pkg::ADDR_NV_CONFIG: rd_data = nv_config_q;
        rnv_pkg::ADDR_CRYSTAL_OFFSET: rd_data = crystal_offset_q;
        rnv_pkg::ADDR_CRYSTAL_QUAD_COEF: rd_data = crystal_quad_coef_q;
        rnv_pkg::ADDR_CRYSTAL_TURNOVER_TEMP:
          rd_data = {2'b00, crystal_turnover_q};
        default: rd_data = rnv_pkg::READ_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  // serial slave; held idle and released while on backup supply
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      read_dir_q <= 1'b0;
      ptr_loaded_q <= 1'b0;
      master_ack_q <= 1'b0;
      drive_low_q <= 1'b0;
      ptr_q <= 8'h00;
      wr_q <= '0;
    end else begin
      wr_q.valid <= 1'b0;
      if (backup_mode_in) begin
        state_q <= ST_IDLE;
        drive_low_q <= 1'b0;
      end else if (start_cond) begin
        state_q <= ST_ADDR;
        bit_cnt_q <= 4'h0;
        drive_low_q <= 1'b0;
      end else if (stop_cond) begin
        state_q <= ST_IDLE;
        drive_low_q <= 1'b0;
      end else begin
        case (state_q)
          ST_IDLE: begin
            drive_low_q <= 1'b0;
          end
          ST_ADDR: begin
            if (scl_rise) begin
              shift_q <= shift_next;
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end else if (scl_fall && bit_cnt_q == rnv_pkg::BITS_PER_BYTE) begin
              if (shift_q[7:1] == BUS_ADDR) begin
                read_dir_q <= shift_q[0];
                drive_low_q <= 1'b1;
                state_q <= ST_ADDR_ACK;
              end else begin
                state_q <= ST_IDLE;
              end
            end
          end
          ST_ADDR_ACK: begin
            if (scl_fall) begin
              bit_cnt_q <= 4'h0;
              ptr_loaded_q <= 1'b0;
              if (read_dir_q) begin
                tx_q <= rd_data;
                drive_low_q <= !rd_data[7];
                ptr_q <= ptr_q + 8'h01;
                state_q <= ST_RD_BYTE;
              end else begin
                drive_low_q <= 1'b0;
                state_q <= ST_WR_BYTE;
              end
            end
          end
          ST_WR_BYTE: begin
            if (scl_rise) begin
              shift_q <= shift_next;
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end else if (scl_fall && bit_cnt_q == rnv_pkg::BITS_PER_BYTE) begin
              drive_low_q <= 1'b1;
              state_q <= ST_WR_ACK;
              if (!ptr_loaded_q) begin
                ptr_q <= shift_q;
                ptr_loaded_q <= 1'b1;
              end else begin
                wr_q.valid <= 1'b1;
                wr_q.addr <= ptr_q;
                wr_q.data <= shift_q;
                ptr_q <= ptr_q + 8'h01;
              end
            end
          end
          ST_WR_ACK: begin
            if (scl_fall) begin
              drive_low_q <= 1'b0;
              bit_cnt_q <= 4'h0;
              state_q <= ST_WR_BYTE;
            end
          end
          ST_RD_BYTE: begin
            if (scl_rise) begin
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt_q == rnv_pkg::BITS_PER_BYTE) begin
                drive_low_q <= 1'b0;
                state_q <= ST_RD_ACK;
              end else begin
                tx_q <= {tx_q[6:0], 1'b0};
                drive_low_q <= !tx_q[6];
              end
            end
          end
          ST_RD_ACK: begin
            if (scl_rise) begin
              master_ack_q <= !sda_in;
            end else if (scl_fall) begin
              bit_cnt_q <= 4'h0;
              if (master_ack_q) begin
                tx_q <= rd_data;
                drive_low_q <= !rd_data[7];
                ptr_q <= ptr_q + 8'h01;
                state_q <= ST_RD_BYTE;
              end else begin
                state_q <= ST_IDLE;
              end
            end
          end
          default: begin
            state_q <= ST_IDLE;
            drive_low_q <= 1'b0;
          end
        endcase
      end
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_n_out = !drive_low_q;

  // factory trim stays writable; protecting it is software's job
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      nv_config_q <= rnv_pkg::NV_CONFIG_RST;
      crystal_offset_q <= rnv_pkg::CRYSTAL_OFFSET_RST;
      crystal_quad_coef_q <= rnv_pkg::CRYSTAL_QUAD_COEF_RST;
      crystal_turnover_q <= rnv_pkg::CRYSTAL_TURNOVER_RST;
    end else if (wr_q.valid) begin
      case (wr_q.addr)
        rnv_pkg::ADDR_NV_CONFIG: nv_config_q <= wr_q.data;
        rnv_pkg::ADDR_CRYSTAL_OFFSET: crystal_offset_q <= wr_q.data;
        rnv_pkg::ADDR_CRYSTAL_QUAD_COEF:
          crystal_quad_coef_q <= wr_q.data;
        rnv_pkg::ADDR_CRYSTAL_TURNOVER_TEMP:
          crystal_turnover_q <= wr_q.data[rnv_pkg::TURNOVER_W-1:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (wr_q.valid && is_user_ram(wr_q.addr)) begin
      user_ram_q[ram_idx(wr_q.addr)] <= wr_q.data;
    end
  end

  // low-supply flags: detection beats a clear in the same cycle
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      low_one_q <= 1'b0;
      low_two_q <= 1'b0;
    end else begin
      low_one_q <= low_supply_level_one_in || (low_one_q && !low_one_clr_in);
      low_two_q <= low_supply_level_two_in || (low_two_q && !low_two_clr_in);
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      int_out <= 1'b0;
    end else begin
      int_out <= (low_one_q && low_one_int_en_in) ||
                 (low_two_q && low_two_int_en_in);
    end
  end

  assign low_one_flag_out = low_one_q;
  assign low_two_flag_out = low_two_q;

  // thermometer stays frozen until the low flags are cleared
  assign therm_en = nv_config_q[rnv_pkg::THERM_EN_BIT];
  assign therm_run = therm_en && !low_one_q && !low_two_q;

  rnv_scan_timer #(
    .SHORT_CYC(SCAN_SHORT_CYC),
    .LONG_CYC(SCAN_LONG_CYC)
  ) u_scan (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .run_in(therm_run),
    .long_sel_in(nv_config_q[rnv_pkg::SCAN_SEL_BIT]),
    .tick_out(scan_tick)
  );

  assign temp_meas_req_out = scan_tick;

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      temp_q <= rnv_pkg::TEMP_RST;
    end else if (!therm_en) begin
      if (wr_q.valid && wr_q.addr == rnv_pkg::ADDR_TEMP) begin
        temp_q <= wr_q.data;
      end
    end else if (therm_run && temp_result_valid_in) begin
      temp_q <= temp_result_in;
    end
  end

  assign temp_value_out = temp_q;

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      trickle_res_largest_en_out <= 1'b0;
      trickle_res_large_en_out <= 1'b0;
      trickle_res_medium_en_out <= 1'b0;
      trickle_res_small_en_out <= 1'b0;
      clock_output_en_out <= 1'b0;
      clock_output_pin_freq_sel_hi_out <= 1'b0;
      clock_output_pin_freq_sel_lo_out <= 1'b0;
    end else begin
      // charging a battery from itself is pointless, so backup cuts it
      trickle_res_largest_en_out <= !backup_mode_in &&
        nv_config_q[rnv_pkg::TRICKLE_LSB+3];
      trickle_res_large_en_out <= !backup_mode_in &&
        nv_config_q[rnv_pkg::TRICKLE_LSB+2];
      trickle_res_medium_en_out <= !backup_mode_in &&
        nv_config_q[rnv_pkg::TRICKLE_LSB+1];
      trickle_res_small_en_out <= !backup_mode_in &&
        nv_config_q[rnv_pkg::TRICKLE_LSB];
      clock_output_en_out <= !backup_mode_in;
      clock_output_pin_freq_sel_hi_out <= nv_config_q[rnv_pkg::CLOCK_OUTPUT_PIN_SEL_LSB+1];
      clock_output_pin_freq_sel_lo_out <= nv_config_q[rnv_pkg::CLOCK_OUTPUT_PIN_SEL_LSB];
    end
  end

  // signed correction: negative means the crystal runs slow
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      comp_out <= '0;
    end else begin
      comp_out.offset <= crystal_offset_q[rnv_pkg::OFFSET_SIGN_BIT] ?
        {1'b0, crystal_offset_q[rnv_pkg::OFFSET_MAG_W-1:0]} :
        8'(-{1'b0, crystal_offset_q[rnv_pkg::OFFSET_MAG_W-1:0]});
      comp_out.quad_coef <= crystal_quad_coef_q;
      comp_out.turnover <= crystal_turnover_q;
    end
  end
endmodule : rnv_config_ram

// ### sim/rnv_config_ram_monitor.sv
// checker: timing relations at the config bank ports
`timescale 1ns/1ps
module rnv_config_ram_monitor #(
  parameter int unsigned SCAN_SHORT_CYC = rnv_pkg::SCAN_SHORT_CYC
) (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic backup_mode_in,
  input wire logic sda_oe_n_out,
  input wire logic low_supply_level_one_in,
  input wire logic low_one_int_en_in,
  input wire logic low_two_int_en_in,
  input wire logic low_one_clr_in,
  input wire logic low_one_flag_out,
  input wire logic low_two_flag_out,
  input wire logic int_out,
  input wire logic temp_meas_req_out,
  input wire logic clock_output_en_out,
  input wire logic trickle_res_largest_en_out
);
  int unsigned gap_q;
  wire want_int = (low_one_flag_out && low_one_int_en_in) ||
    (low_two_flag_out && low_two_int_en_in);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  // zero until a first request, saturates so it never wraps
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      gap_q <= 32'h0;
    end else if (temp_meas_req_out) begin
      gap_q <= 32'h1;
    end else if (gap_q != 32'h0 && gap_q != 32'hFFFFFFFF) begin
      gap_q <= gap_q + 32'h1;
    end
  end
  property p_backup_off;
    backup_mode_in |=> !clock_output_en_out && !trickle_res_largest_en_out;
  endproperty
  a_backup_off: assert property (p_backup_off) else $error("backup on");
  property p_clk_en;
    !backup_mode_in |=> clock_output_en_out;
  endproperty
  a_clk_en: assert property (p_clk_en) else $error("clock out off");
  property p_backup_sda;
    backup_mode_in && $past(backup_mode_in) |-> sda_oe_n_out;
  endproperty
  a_backup_sda: assert property (p_backup_sda) else $error("sda driven");
  property p_int_set;
    want_int |=> int_out;
  endproperty
  a_int_set: assert property (p_int_set) else $error("int missing");
  property p_int_clr;
    !want_int |=> !int_out;
  endproperty
  a_int_clr: assert property (p_int_clr) else $error("int spurious");
  property p_flag_hold;
    low_supply_level_one_in || (low_one_flag_out && !low_one_clr_in)
      |=> low_one_flag_out;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost");
  property p_scan_freeze;
    low_one_flag_out || low_two_flag_out |=> !temp_meas_req_out;
  endproperty
  a_scan_freeze: assert property (p_scan_freeze) else $error("scan low");
  property p_req_gap;
    temp_meas_req_out && gap_q != 32'h0 |-> gap_q >= SCAN_SHORT_CYC;
  endproperty
  a_req_gap: assert property (p_req_gap) else $error("scan too soon");
endmodule : rnv_config_ram_monitor

bind rnv_config_ram rnv_config_ram_monitor #(
  .SCAN_SHORT_CYC(SCAN_SHORT_CYC)) i_rnv_config_ram_monitor (
  .core_clk_in(core_clk_in), .nrst_in(nrst_in),
  .backup_mode_in(backup_mode_in), .sda_oe_n_out(sda_oe_n_out),
  .low_supply_level_one_in(low_supply_level_one_in),
  .low_one_int_en_in(low_one_int_en_in),
  .low_two_int_en_in(low_two_int_en_in), .low_one_clr_in(low_one_clr_in),
  .low_one_flag_out(low_one_flag_out), .low_two_flag_out(low_two_flag_out),
  .int_out(int_out), .temp_meas_req_out(temp_meas_req_out),
  .clock_output_en_out(clock_output_en_out),
  .trickle_res_largest_en_out(trickle_res_largest_en_out));

// ### sim/rnv_host_model.sv
// host model: open-drain two-wire master with register tasks
`timescale 1ns/1ps
module rnv_host_model (
  input wire logic core_clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out,
  output logic res_stb_out,
  output logic [7:0] res_out
);
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
    res_stb_out = 1'b0;
    res_out = 8'h00;
  end
  task automatic drive(input logic c, input logic d, input int k);
    scl_out = c;
    sda_out = d;
    repeat (k) @(posedge core_clk_in);
    #1;
  endtask : drive
  // data moves only while scl is low
  task automatic bit_io(input logic b, output logic r);
    drive(1'b0, b, 4);
    drive(1'b1, b, 3);
    r = sda_in;
    drive(1'b1, b, 3);
    drive(1'b0, b, 2);
  endtask : bit_io
  task automatic byte_io(input logic [7:0] wb, input logic last,
                         output logic [7:0] rb, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(wb[i], rb[i]);
    bit_io(last, ack);
    ack = !ack;
  endtask : byte_io
  task automatic report(input logic [7:0] x);
    res_out = x;
    res_stb_out = 1'b1;
    drive(scl_out, sda_out, 1);
    res_stb_out = 1'b0;
  endtask : report
  task automatic send_start(input logic [7:0] a, output logic ack);
    logic [7:0] rb;
    drive(scl_out, 1'b1, 2);
    drive(1'b1, 1'b1, 4);
    drive(1'b1, 1'b0, 4);
    drive(1'b0, 1'b0, 2);
    byte_io(a, 1'b1, rb, ack);
    report({7'h00, ack});
  endtask : send_start
  task automatic send_stop;
    drive(1'b0, 1'b0, 2);
    drive(1'b1, 1'b0, 4);
    drive(1'b1, 1'b1, 4);
  endtask : send_stop
  task automatic wr(input logic [6:0] dev, input logic [7:0] ptr,
                    input logic [63:0] data, input int n);
    logic [7:0] rb;
    logic ack;
    send_start({dev, 1'b0}, ack);
    if (ack) begin
      byte_io(ptr, 1'b1, rb, ack);
      for (int i = 0; i < n; i++) byte_io(data[8*i+:8], 1'b1, rb, ack);
    end
    send_stop();
  endtask : wr
  // a refused address is not checked; the pointer and read bytes are still clocked
  task automatic rd(input logic [6:0] dev, input logic [7:0] ptr, input int n);
    logic [7:0] rb;
    logic ack;
    send_start({dev, 1'b0}, ack);
    byte_io(ptr, 1'b1, rb, ack);
    send_start({dev, 1'b1}, ack);
    for (int i = 0; i < n; i++) begin
      byte_io(8'hFF, i == n - 1, rb, ack);
      report(rb);
    end
    send_stop();
  endtask : rd
endmodule : rnv_host_model

// ### sim/tb_rnv_config_ram.sv
// bench: register bank driven through the two-wire host model
`timescale 1ns/1ps
module tb_rnv_config_ram;
  localparam int unsigned SHORT = 20;
  localparam int unsigned LONG = 50;
  localparam logic [6:0] DEV = rnv_pkg::BUS_ADDR_DEFAULT;
  logic core_clk_in = 1'b0, nrst_in = 1'b0, bkup = 1'b0, tvalid = 1'b0;
  logic lv1 = 1'b0, lv2 = 1'b0, en1 = 1'b0, en2 = 1'b0;
  logic clr1 = 1'b0, clr2 = 1'b0;
  logic [7:0] tres = 8'h00;
  logic scl, hsda, oe_n, sdo, req, stb, f1, f2, irq, ck_en;
  logic [7:0] res, tval, v, last_t;
  logic [3:0] trk;
  logic [1:0] fsel;
  logic [63:0] blk;
  logic [1:0] ef = 2'b00;
  logic ei;
  rnv_pkg::rnv_comp_type comp;
  logic [7:0] exp_q[$];
  logic [7:0] zr[7] = '{8'h30, 8'h31, 8'h32, 8'h33, 8'h20, 8'h34, 8'h40};
  int fails = 0, cmp_count = 0, cycles = 0, seed = 68, n;
  wire logic sda_line = hsda & (oe_n | sdo);
  always #4 core_clk_in = ~core_clk_in;
  rnv_config_ram #(.SCAN_SHORT_CYC(SHORT), .SCAN_LONG_CYC(LONG))
    i_rnv_config_ram (
    .core_clk_in(core_clk_in), .nrst_in(nrst_in), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sdo), .sda_oe_n_out(oe_n),
    .backup_mode_in(bkup), .low_supply_level_one_in(lv1),
    .low_supply_level_two_in(lv2), .low_one_int_en_in(en1),
    .low_two_int_en_in(en2), .low_one_clr_in(clr1), .low_two_clr_in(clr2),
    .temp_result_in(tres), .temp_result_valid_in(tvalid),
    .temp_meas_req_out(req), .temp_value_out(tval),
    .trickle_res_largest_en_out(trk[3]), .trickle_res_large_en_out(trk[2]),
    .trickle_res_medium_en_out(trk[1]), .trickle_res_small_en_out(trk[0]),
    .clock_output_en_out(ck_en), .clock_output_pin_freq_sel_hi_out(fsel[1]),
    .clock_output_pin_freq_sel_lo_out(fsel[0]), .low_one_flag_out(f1),
    .low_two_flag_out(f2), .int_out(irq), .comp_out(comp));
  rnv_host_model i_rnv_host_model (.core_clk_in(core_clk_in),
    .sda_in(sda_line), .scl_out(scl), .sda_out(hsda),
    .res_stb_out(stb), .res_out(res));
  task automatic compare(input string what, input logic [7:0] s,
                         input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, e, s);
    end
  endtask : compare
  task automatic give_verdict;
    $display("mismatches %0d comparisons %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk_in);
    #1;
  endtask : tick
  task automatic wreg(input logic [7:0] a, d, input logic ok);
    exp_q.push_back({7'h00, ok});
    i_rnv_host_model.wr(DEV, a, {56'h0, d}, 1);
  endtask : wreg
  task automatic rreg(input logic [7:0] a, d);
    exp_q.push_back(8'h01);
    exp_q.push_back(8'h01);
    exp_q.push_back(d);
    i_rnv_host_model.rd(DEV, a, 1);
  endtask : rreg
  // gives up after 200 cycles, so a missing request shows as 200
  task automatic wait_req(output int k);
    k = 0;
    do begin
      tick(1);
      k++;
    end while (req !== 1'b1 && k < 200);
  endtask : wait_req
  always @(posedge core_clk_in) begin
    if (stb === 1'b1) begin
      compare("bus result", res,
              exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX);
    end
  end
  always @(posedge core_clk_in) begin
    if (req === 1'b1) begin
      #1;
      last_t = 8'($random(seed));
      tres = last_t;
      tvalid = 1'b1;
      tick(1);
      tvalid = 1'b0;
    end
  end
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles >= 60000) begin
      fails++;
      give_verdict();
    end
  end
  initial begin
    tick(6);
    nrst_in = 1'b1;
    tick(2);
    foreach (zr[i]) rreg(zr[i], 8'h00);
    compare("clock enable", {7'h00, ck_en}, 8'h01);
    for (int i = 0; i < 4; i++) begin
      v = (8'h10 << i) | 8'(i << 2);
      wreg(8'h30, v, 1'b1);
      rreg(8'h30, v);
      compare("trickle", {4'h0, trk}, {4'h0, v[7:4]});
      compare("clock_output_pin select", {6'h00, fsel}, {6'h00, v[3:2]});
    end
    for (int s = 0; s < 2; s++) begin
      n = int'($unsigned($random(seed)) % 122);
      v = {s[0], 7'(n)};
      wreg(8'h31, v, 1'b1);
      rreg(8'h31, v);
      compare("offset", comp.offset,
              s ? {1'b0, v[6:0]} : 8'h00 - {1'b0, v[6:0]});
    end
    v = 8'($random(seed));
    wreg(8'h32, v, 1'b1);
    compare("quad coef", comp.quad_coef, v);
    wreg(8'h33, 8'hFF, 1'b1);
    rreg(8'h33, 8'h3F);
    compare("turnover", {2'h0, comp.turnover}, 8'h3F);
    exp_q.push_back(8'h01);
    i_rnv_host_model.wr(DEV, 8'h31, 64'h0, 3);
    blk = {$random(seed), $random(seed)};
    exp_q.push_back(8'h01);
    i_rnv_host_model.wr(DEV, 8'h38, blk, 8);
    exp_q.push_back(8'h01);
    exp_q.push_back(8'h01);
    for (int i = 0; i < 8; i++) exp_q.push_back(blk[8*i+:8]);
    i_rnv_host_model.rd(DEV, 8'h38, 8);
    wreg(8'h20, 8'h5A, 1'b1);
    rreg(8'h20, 8'h5A);
    for (int s = 0; s < 2; s++) begin
      wreg(8'h30, 8'h02 | 8'(s), 1'b1);
      wait_req(n);
      wait_req(n);
      compare("scan interval", 8'(n), s ? 8'(LONG) : 8'(SHORT));
      tick(5);
      compare("temperature", tval, last_t);
    end
    wreg(8'h30, 8'h00, 1'b1);
    tick(80);
    compare("frozen temperature", tval, last_t);
    en1 = 1'b1;
    lv1 = 1'b1;
    tick(1);
    lv1 = 1'b0;
    tick(3);
    compare("level one", {6'h00, f1, irq}, 8'h03);
    clr1 = 1'b1;
    tick(1);
    clr1 = 1'b0;
    tick(3);
    compare("level one cleared", {6'h00, f1, irq}, 8'h00);
    lv2 = 1'b1;
    tick(1);
    lv2 = 1'b0;
    wreg(8'h30, 8'h02, 1'b1);
    compare("masked level two", {6'h00, f2, irq}, 8'h02);
    wait_req(n);
    compare("scan while low", 8'(n), 8'hC8);
    en2 = 1'b1;
    tick(3);
    compare("level two", {6'h00, f2, irq}, 8'h03);
    clr2 = 1'b1;
    tick(1);
    clr2 = 1'b0;
    tick(3);
    compare("level two cleared", {6'h00, f2, irq}, 8'h00);
    // random supply events, clears and masks; a set beats a clear
    for (int i = 0; i < 16; i++) begin
      v = 8'($random(seed));
      {lv1, lv2, en1, en2, clr1, clr2} = v[5:0];
      ei = (ef[1] && en1) || (ef[0] && en2);
      ef = {lv1 || (ef[1] && !clr1), lv2 || (ef[0] && !clr2)};
      tick(1);
      compare("random flags", {5'h00, f1, f2, irq}, {5'h00, ef, ei});
    end
    {lv1, lv2, clr1, clr2} = 4'h3;
    tick(1);
    {clr1, clr2} = 2'h0;
    wreg(8'h30, 8'hF0, 1'b1);
    bkup = 1'b1;
    tick(3);
    compare("backup outputs", {3'h0, ck_en, trk}, 8'h00);
    wreg(8'h30, 8'h00, 1'b0);
    bkup = 1'b0;
    tick(3);
    rreg(8'h30, 8'hF0);
    exp_q.push_back(8'h00);
    i_rnv_host_model.wr(DEV ^ 7'h01, 8'h30, 64'h0, 1);
    rreg(8'h30, 8'hF0);
    tick(20);
    compare("pending results", 8'(exp_q.size()), 8'h00);
    give_verdict();
  end
endmodule : tb_rnv_config_ram
